//--- hdl/sig_sup.sv
// supervision channel 1 with apb register file
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module sig_sup
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // monitored signal sources, flattened, index = selection code
  input wire logic [sig_sup_pkg::NUM_SRC*sig_sup_pkg::DATA_W-1:0] SRC_BUS,
  input wire logic RUNNING,
  // drive fault and warning handling
  output logic SUP_ACTIVE,
  output logic WARNING,
  output logic FAULT,
  output logic [15:0] EVENT_CODE,
  output logic IRQ
);
  import sig_sup_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [DATA_W:0] mag(input logic [DATA_W-1:0] v);
    logic [DATA_W:0] x;
    x = {v[DATA_W-1], v};
    mag = v[DATA_W-1] ? (~x + 1'b1) : x;
  endfunction : mag

  function automatic logic signed [DATA_W+1:0] ext(input logic [DATA_W-1:0] v);
    ext = signed'({{2{v[DATA_W-1]}}, v});
  endfunction : ext

  // ----------------------------------------
  // register file
  // ----------------------------------------
  sup_mode_t mode, next_mode;
  sup_action_t action, next_action;
  logic [4:0] sel, next_sel;
  logic [DATA_W-1:0] lim_low, next_lim_low, lim_high, next_lim_high;
  logic [DATA_W-1:0] hyst, next_hyst;
  logic [1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic [31:0] next_prdata;
  logic wr, setup_rd, hit;
  logic viol, next_viol, warn_now, fault_now;

  assign wr = PSEL && PENABLE && PWRITE;
  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;

  always_comb
  begin
    hit = 1'b1;
    unique case (PADDR)
      OFS_MODE, OFS_ACTION, OFS_SELECT, OFS_LOW, OFS_HIGH,
      OFS_HYST, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && !hit;

  always_comb
  begin
    next_mode = mode;
    next_action = action;
    next_sel = sel;
    next_lim_low = lim_low;
    next_lim_high = lim_high;
    next_hyst = hyst;
    next_irq_mask = irq_mask;
    next_prdata = PRDATA;
    // set wins over write-one-to-clear
    next_irq_stat = irq_stat;
    if (wr && PADDR == OFS_IRQ_STAT)
      next_irq_stat = irq_stat & ~PWDATA[1:0];
    if (warn_now)
      next_irq_stat[IRQ_WARN_BIT] = 1'b1;
    if (fault_now)
      next_irq_stat[IRQ_FAULT_BIT] = 1'b1;
    if (wr)
    begin
      unique case (PADDR)
        OFS_MODE: next_mode = sup_mode_t'(PWDATA[2:0]);
        OFS_ACTION: next_action = sup_action_t'(PWDATA[1:0]);
        OFS_SELECT: next_sel = PWDATA[4:0];
        OFS_LOW: next_lim_low = PWDATA[DATA_W-1:0];
        OFS_HIGH: next_lim_high = PWDATA[DATA_W-1:0];
        OFS_HYST: next_hyst = PWDATA[DATA_W-1:0];
        OFS_IRQ_MASK: next_irq_mask = PWDATA[1:0];
        default: ;
      endcase
    end
    // captured in setup so the flop holds it through the access phase
    if (setup_rd)
    begin
      unique case (PADDR)
        OFS_MODE: next_prdata = {29'h0, mode};
        OFS_ACTION: next_prdata = {30'h0, action};
        OFS_SELECT: next_prdata = {27'h0, sel};
        OFS_LOW: next_prdata = {16'h0, lim_low};
        OFS_HIGH: next_prdata = {16'h0, lim_high};
        OFS_HYST: next_prdata = {16'h0, hyst};
        OFS_STATUS: next_prdata = {31'h0, viol};
        OFS_IRQ_STAT: next_prdata = {30'h0, irq_stat};
        OFS_IRQ_MASK: next_prdata = {30'h0, irq_mask};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  // read data comes from a flop loaded in setup; zero waits still hold,
  // a status change during the access phase shows on the next read
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      mode <= MODE_DISABLED;
      action <= ACT_NONE;
      sel <= RST_SELECT;
      lim_low <= RST_LIMIT;
      lim_high <= RST_LIMIT;
      hyst <= RST_LIMIT;
      irq_stat <= RST_IRQ;
      irq_mask <= RST_IRQ;
      PRDATA <= '0;
    end
    else
    begin
      mode <= next_mode;
      action <= next_action;
      sel <= next_sel;
      lim_low <= next_lim_low;
      lim_high <= next_lim_high;
      hyst <= next_hyst;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      PRDATA <= next_prdata;
    end
  end

  // ----------------------------------------
  // comparison
  // ----------------------------------------
  logic [DATA_W-1:0] sig;
  logic signed [DATA_W+1:0] s, lo, hi, half;
  logic [DATA_W:0] ms, mlo, mhi;

  always_comb
  begin
    // code 0 reads as zero regardless of the source wired there
    sig = (sel == SEL_ZERO) ? '0 : SRC_BUS[sel*DATA_W +: DATA_W];
    s = ext(sig);
    lo = ext(lim_low);
    hi = ext(lim_high);
    half = signed'({2'b00, hyst}) >>> 1;
    ms = mag(sig);
    mlo = mag(lim_low);
    mhi = mag(lim_high);
    next_viol = 1'b0;
    unique case (mode)
      MODE_DISABLED: next_viol = 1'b0;
      MODE_LOW: next_viol = s < lo;
      MODE_HIGH: next_viol = s > hi;
      MODE_ABS_LOW: next_viol = ms < mlo;
      MODE_ABS_HIGH: next_viol = ms > mhi;
      MODE_BOTH: next_viol = (s < lo) || (s > hi);
      MODE_ABS_BOTH: next_viol = (ms < mlo) || (ms > mhi);
      // hysteresis is centred on the upper limit
      MODE_HYST:
      begin
        if (s > hi + half)
          next_viol = 1'b1;
        else if (s < hi - half)
          next_viol = 1'b0;
        else
          next_viol = viol;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      viol <= 1'b0;
    else
      viol <= next_viol;
  end

  // ----------------------------------------
  // actions
  // ----------------------------------------
  logic next_warn, next_fault;
  logic [15:0] next_code;

  // built from next values so the levels move on the same edge as the flag
  always_comb
  begin
    next_warn = next_viol && next_action == ACT_WARNING;
    next_fault = next_viol && (next_action == ACT_FAULT
                 || (next_action == ACT_FAULT_RUN && RUNNING));
    next_code = CODE_NONE;
    if (next_fault)
      next_code = CODE_FAULT;
    else if (next_warn)
      next_code = CODE_WARNING;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      warn_now <= 1'b0;
      fault_now <= 1'b0;
      EVENT_CODE <= CODE_NONE;
    end
    else
    begin
      warn_now <= next_warn;
      fault_now <= next_fault;
      EVENT_CODE <= next_code;
    end
  end

  assign SUP_ACTIVE = viol;
  assign WARNING = warn_now;
  assign FAULT = fault_now;
  assign IRQ = |(irq_stat & irq_mask);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_disabled;
    @(posedge CLK) disable iff (!RESET_N)
    (mode == MODE_DISABLED) |=> !viol;
  endproperty
  a_disabled: assert property (p_disabled) else $error("violation while disabled");

  property p_low;
    @(posedge CLK) disable iff (!RESET_N)
    (mode == MODE_LOW) |=> (viol == $past(s < lo));
  endproperty
  a_low: assert property (p_low) else $error("low mode mismatch");

  property p_high;
    @(posedge CLK) disable iff (!RESET_N)
    (mode == MODE_HIGH) |=> (viol == $past(s > hi));
  endproperty
  a_high: assert property (p_high) else $error("high mode mismatch");

  property p_abs_high;
    @(posedge CLK) disable iff (!RESET_N)
    (mode == MODE_ABS_HIGH) |=> (viol == $past(ms > mhi));
  endproperty
  a_abs_high: assert property (p_abs_high) else $error("abs high mismatch");

  property p_hyst_hold;
    @(posedge CLK) disable iff (!RESET_N)
    (mode == MODE_HYST && s <= hi + half && s >= hi - half) |=> $stable(viol);
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis band moved");

  property p_no_action;
    @(posedge CLK) disable iff (!RESET_N)
    (action == ACT_NONE) |-> !WARNING && !FAULT;
  endproperty
  a_no_action: assert property (p_no_action) else $error("action raised with none");

  property p_fault_run;
    @(posedge CLK) disable iff (!RESET_N)
    (action == ACT_FAULT_RUN && viol) |-> (FAULT == $past(RUNNING));
  endproperty
  a_fault_run: assert property (p_fault_run) else $error("fault if running wrong");

  property p_codes;
    @(posedge CLK) disable iff (!RESET_N)
    (FAULT |-> EVENT_CODE == CODE_FAULT) and (WARNING |-> EVENT_CODE == CODE_WARNING);
  endproperty
  a_codes: assert property (p_codes) else $error("event code wrong");

  property p_status;
    @(posedge CLK) disable iff (!RESET_N)
    (mode == MODE_BOTH && action == ACT_NONE) |=> (SUP_ACTIVE == $past((s < lo) || (s > hi)));
  endproperty
  a_status: assert property (p_status) else $error("status not following");

  property p_abs_low;
    @(posedge CLK) disable iff (!RESET_N)
    (mode == MODE_ABS_LOW) |=> (viol == $past(ms < mlo));
  endproperty
  a_abs_low: assert property (p_abs_low) else $error("abs low mismatch");

  property p_both;
    @(posedge CLK) disable iff (!RESET_N)
    (mode == MODE_BOTH) |=> (viol == $past((s < lo) || (s > hi)));
  endproperty
  a_both: assert property (p_both) else $error("both mode mismatch");

  property p_abs_both;
    @(posedge CLK) disable iff (!RESET_N)
    (mode == MODE_ABS_BOTH) |=> (viol == $past((ms < mlo) || (ms > mhi)));
  endproperty
  a_abs_both: assert property (p_abs_both) else $error("abs both mismatch");

  // crossing a band edge moves the flag, inside the band it holds
  sequence s_hyst_above;
    (mode == MODE_HYST) && (s > hi + half);
  endsequence

  sequence s_hyst_below;
    (mode == MODE_HYST) && (s < hi - half);
  endsequence

  property p_hyst_set;
    @(posedge CLK) disable iff (!RESET_N)
    s_hyst_above |=> viol;
  endproperty
  a_hyst_set: assert property (p_hyst_set) else $error("hysteresis did not set");

  property p_hyst_clear;
    @(posedge CLK) disable iff (!RESET_N)
    s_hyst_below |=> !viol;
  endproperty
  a_hyst_clear: assert property (p_hyst_clear) else $error("hysteresis did not clear");

  property p_warning;
    @(posedge CLK) disable iff (!RESET_N)
    (viol && action == ACT_WARNING) |-> (WARNING && !FAULT);
  endproperty
  a_warning: assert property (p_warning) else $error("warning level wrong");

  property p_fault;
    @(posedge CLK) disable iff (!RESET_N)
    (viol && action == ACT_FAULT) |-> (FAULT && !WARNING);
  endproperty
  a_fault: assert property (p_fault) else $error("fault level wrong");

  property p_event_none;
    @(posedge CLK) disable iff (!RESET_N)
    (!WARNING && !FAULT) |-> (EVENT_CODE == CODE_NONE);
  endproperty
  a_event_none: assert property (p_event_none) else $error("stray event code");

  property p_zero_sel;
    @(posedge CLK) disable iff (!RESET_N)
    (sel == SEL_ZERO && mode == MODE_HIGH && !lim_high[DATA_W-1]) |=> !viol;
  endproperty
  a_zero_sel: assert property (p_zero_sel) else $error("zero selection flagged");

  property p_status_word;
    @(posedge CLK) disable iff (!RESET_N)
    (setup_rd && PADDR == OFS_STATUS) |=> (PRDATA[0] == $past(viol)) && (PRDATA[31:1] == '0);
  endproperty
  a_status_word: assert property (p_status_word) else $error("status word wrong");

  property p_mode_reg;
    @(posedge CLK) disable iff (!RESET_N)
    (wr && PADDR == OFS_MODE) |=> (mode == sup_mode_t'($past(PWDATA[2:0])));
  endproperty
  a_mode_reg: assert property (p_mode_reg) else $error("mode write lost");

  property p_hyst_reg;
    @(posedge CLK) disable iff (!RESET_N)
    (wr && PADDR == OFS_HYST) |=> (hyst == $past(PWDATA[DATA_W-1:0]));
  endproperty
  a_hyst_reg: assert property (p_hyst_reg) else $error("hysteresis write lost");

  property p_sel_reg;
    @(posedge CLK) disable iff (!RESET_N)
    (wr && PADDR == OFS_SELECT) |=> (sel == $past(PWDATA[4:0]));
  endproperty
  a_sel_reg: assert property (p_sel_reg) else $error("selection write lost");
endmodule : sig_sup

//--- hdl/sig_sup_pkg.sv
// constants and types for signal limit supervision channel 1
package sig_sup_pkg;
  localparam int DATA_W = 16;
  localparam int NUM_SRC = 32;
  typedef enum logic [2:0]
  {
    MODE_DISABLED, MODE_LOW, MODE_HIGH, MODE_ABS_LOW,
    MODE_ABS_HIGH, MODE_BOTH, MODE_ABS_BOTH, MODE_HYST
  } sup_mode_t;
  typedef enum logic [1:0]
  {
    ACT_NONE, ACT_WARNING, ACT_FAULT, ACT_FAULT_RUN
  } sup_action_t;
  // register byte offsets
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_ACTION = 12'h004;
  localparam logic [11:0] OFS_SELECT = 12'h008;
  localparam logic [11:0] OFS_LOW = 12'h00c;
  localparam logic [11:0] OFS_HIGH = 12'h010;
  localparam logic [11:0] OFS_HYST = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h01c;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h020;
  // selection codes and reset values
  localparam logic [4:0] SEL_ZERO = 5'h00;
  localparam logic [4:0] SEL_FREQ = 5'h03;
  localparam logic [4:0] RST_SELECT = SEL_FREQ;
  localparam logic [DATA_W-1:0] RST_LIMIT = 16'h0000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // event codes
  localparam logic [15:0] CODE_WARNING = 16'ha8b0;
  localparam logic [15:0] CODE_FAULT = 16'h80b0;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  // interrupt status bit positions
  localparam int IRQ_WARN_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
endpackage : sig_sup_pkg

//--- testbench/drive_handler.sv
// model of the drive fault and warning handling
`timescale 1ns/1ps
module drive_handler
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // supervision events
  input wire logic warning,
  input wire logic fault,
  input wire logic [15:0] event_code,
  // recorded state
  output logic tripped,
  output logic [15:0] last_code
);
  // a trip latches until reset, as a stopped drive stays down
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tripped <= 1'b0;
      last_code <= 16'h0000;
    end
    else if (warning || fault)
    begin
      tripped <= tripped | fault;
      last_code <= event_code;
    end
  end
endmodule : drive_handler

//--- testbench/tb_sig_sup.sv
// self-checking bench for supervision channel 1
`timescale 1ns/1ps
module tb_sig_sup;
  import sig_sup_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic running = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, perr, sup_active, warning, fault, irq, tripped;
  logic [15:0] event_code, last_code;
  logic [NUM_SRC*DATA_W-1:0] src = '0;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  // {mode, signal, violation}; limits -100 and 200, strict edges
  logic [19:0] mtab [15] = '{{3'h1, 16'hff9b, 1'h1}, {3'h1, 16'hff9c, 1'h0},
    {3'h2, 16'h00c9, 1'h1}, {3'h2, 16'h00c8, 1'h0}, {3'h3, 16'hff9d, 1'h1},
    {3'h3, 16'hff6a, 1'h0}, {3'h4, 16'hff37, 1'h1}, {3'h4, 16'h0096, 1'h0},
    {3'h5, 16'hff9b, 1'h1}, {3'h5, 16'h00c9, 1'h1}, {3'h5, 16'h0000, 1'h0},
    {3'h6, 16'hff37, 1'h1}, {3'h6, 16'h0032, 1'h1}, {3'h6, 16'hff6a, 1'h0},
    {3'h0, 16'hfed4, 1'h0}};
  // band 190..210 around the upper limit
  logic [16:0] htab [7] = '{{16'h0000, 1'h0}, {16'h00d2, 1'h0}, {16'h00d3, 1'h1},
    {16'h00c3, 1'h1}, {16'h00be, 1'h1}, {16'h00bd, 1'h0}, {16'h00cd, 1'h0}};
  // {action, running, warning, fault, code}
  logic [20:0] atab [5] = '{{2'h0, 3'h0, CODE_NONE}, {2'h1, 3'h2, CODE_WARNING},
    {2'h2, 3'h1, CODE_FAULT}, {2'h3, 3'h0, CODE_NONE}, {2'h3, 3'h5, CODE_FAULT}};

  sig_sup i_dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SRC_BUS(src), .RUNNING(running),
    .SUP_ACTIVE(sup_active), .WARNING(warning), .FAULT(fault),
    .EVENT_CODE(event_code), .IRQ(irq));
  drive_handler i_drive (.clk(clk), .reset_n(reset_n), .warning(warning),
    .fault(fault), .event_code(event_code), .tripped(tripped), .last_code(last_code));

  always #10 clk = ~clk;

  // -----------------------
  // tasks
  // -----------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // a hang in any wait ends here
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // new signal value, then one edge to register and one to spare
  task automatic drive(input int k, input logic [15:0] v);
    @(posedge clk);
    src[k*DATA_W +: DATA_W] <= v;
    repeat (2) @(posedge clk);
    #1;
  endtask : drive

  task automatic viol(input logic e);
    chk(32'(sup_active), 32'(e));
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'(e));
  endtask : viol

  // -----------------------
  // sequence
  // -----------------------
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, (i == 2) ? 32'(SEL_FREQ) : 32'h0);
    end
    chk(32'({sup_active, warning, fault, irq, event_code}), 32'h0);
    apb(1'b1, 12'h024, 32'hffffffff);
    apb(1'b0, 12'h024, 32'h0);
    chk({rd[30:0], perr}, 32'h1);
    apb(1'b1, OFS_LOW, 32'h0000ff9c);
    apb(1'b1, OFS_HIGH, 32'h000000c8);
    foreach (mtab[i])
    begin
      apb(1'b1, OFS_MODE, 32'(mtab[i][19:17]));
      drive(3, mtab[i][16:1]);
      viol(mtab[i][0]);
      chk(32'(warning | fault), 32'h0);
    end
    apb(1'b1, OFS_HYST, 32'h00000014);
    apb(1'b1, OFS_MODE, 32'h00000007);
    foreach (htab[i])
    begin
      drive(3, htab[i][16:1]);
      viol(htab[i][0]);
    end
    apb(1'b1, OFS_MODE, 32'h00000002);
    drive(3, 16'h012c);
    foreach (atab[i])
    begin
      apb(1'b1, OFS_ACTION, 32'(atab[i][20:19]));
      @(posedge clk);
      running <= atab[i][18];
      repeat (2) @(posedge clk);
      #1;
      chk({warning, fault, event_code}, 32'(atab[i][17:0]));
    end
    chk({tripped, last_code}, {16'h1, CODE_FAULT});
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({rd[30:0], irq}, 32'h6);
    apb(1'b1, OFS_IRQ_MASK, 32'h00000001);
    #1;
    chk(32'(irq), 32'h1);
    apb(1'b1, OFS_ACTION, 32'h0);
    apb(1'b1, OFS_IRQ_STAT, 32'h00000003);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({rd[30:0], irq}, 32'h0);
    apb(1'b1, OFS_SELECT, 32'(SEL_ZERO));
    drive(0, 16'h012c);
    viol(1'b0);
    apb(1'b1, OFS_SELECT, 32'h00000005);
    drive(5, 16'h012c);
    viol(1'b1);
    wrap_up();
  end
endmodule : tb_sig_sup
